// ==== hdl/dsp_pkg.sv ====
// shared constants and types for the dual-protocol serial configuration port
package dsp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // frame geometry
    localparam int FRAME_BITS = 32;
    localparam int DATA_W = 24;
    localparam int ST_ADDR_W = 6;
    localparam int SB_ADDR_W = 5;
    localparam int CHIP_W = 3;
    localparam int REG_COUNT = 32;

    // rising-edge numbers inside a frame (count is 1-based)
    localparam logic [5:0] EDGE_FIRST = 6'h01;
    localparam logic [5:0] EDGE_ST_DATA = 6'h08;
    localparam logic [5:0] EDGE_LAST = 6'h20;
    localparam logic [5:0] EDGE_OVER = 6'h21;

    // single-target frame: bit positions in the shift register before edge 32 (ST_RW_AT_LOAD: before edge 8)
    localparam int ST_RW_POS = 30;
    localparam int ST_ADDR_LSB = 24;
    localparam int ST_RW_AT_LOAD = 6;
    // shared-bus frame: bit positions in the 32-bit frame after edge 32
    localparam int SB_DATA_LSB = 8;
    localparam int SB_ADDR_LSB = 3;

    ////////////////////////////////////////////////////////////////////////////
    // identity_and_read_pointer register
    localparam logic [5:0] REG_ID = 6'h00;
    localparam int PTR_LSB = 0;
    localparam int PTR_W = 5;
    localparam int SOFT_RST_BIT = 5;
    localparam int STROBE_LSB = 6;
    localparam logic [2:0] CHIP_SELF = 3'h0;
    // part identifier: value is arbitrary
    localparam logic [23:0] PART_ID = 24'h5A0C3E;
    localparam logic [23:0] REG_RESET = 24'h000000;

    // protocol_o encoding
    localparam int PROTO_ST_BIT = 0;
    localparam int PROTO_SB_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // host timing, system clock 100 MHz
    localparam int SYS_PERIOD_NS = 10;
    localparam int HALF_PERIOD_NS = 40;
    localparam int T_SEN_SETUP_NS = 8;
    localparam int T_SEN_HIGH_NS = 10;
    localparam int T_SEN_LOW_NS = 20;
    localparam int HALF_CYC = (HALF_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int SETUP_CYC = (T_SEN_SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int HIGH_CYC = (T_SEN_HIGH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int LOW_CYC = (T_SEN_LOW_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [3:0] PHASE_RISE = 4'h0;
    localparam logic [3:0] PHASE_FALL = 4'(HALF_CYC);
    localparam logic [3:0] PHASE_WRAP = 4'(2 * HALF_CYC - 1);

    typedef enum logic [5:0] {
        H_IDLE = 6'h01,
        H_SETUP = 6'h02,
        H_SHIFT = 6'h04,
        H_END = 6'h08,
        H_HIGH = 6'h10,
        H_REST = 6'h20
    } dsp_host_state_t;

endpackage : dsp_pkg

// ==== hdl/dsp_link_if.sv ====
// link wires between the serial master and the configuration port
`timescale 1ns/1ns
interface dsp_link_if;
    logic shift_clk;
    logic frame_strobe;
    logic serial_in_line;
    logic readback_data;
    logic readback_sel;
    logic readback_oe;
    logic lock_level;
    logic lock_or_readback_pin;

    // shared pin: read data during frames, lock indicator otherwise, low when undriven
    assign lock_or_readback_pin = readback_oe ? (readback_sel ? readback_data : lock_level)
                                              : 1'b0;

    modport device (
        input shift_clk,
        input frame_strobe,
        input serial_in_line,
        output readback_data,
        output readback_sel,
        output readback_oe,
        output lock_level
    );

    modport host (
        output shift_clk,
        output frame_strobe,
        output serial_in_line,
        input lock_or_readback_pin
    );
endinterface : dsp_link_if

// ==== hdl/dsp_sync2.sv ====
// two-flop synchroniser for levels and toggles
`timescale 1ns/1ns
module dsp_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : dsp_sync2

// ==== hdl/dsp_device.sv ====
// configuration port end: protocol choice, frame decode, register file, readback
// Notes on behaviour
// - first strobe rise or clock rise picks protocol
// - chosen protocol stays until power cycle
// - soft reset keeps the chosen protocol
// - single-target frame: flag, 6 address, 24 data
// - first rising edge samples flag, low writes
// - address MSB first on edges 2 to 7
// - write data MSB first on edges 8 to 31
// - single-target write commits on edge 32
// - flag high on first edge starts read
// - read drives 24 bits on edges 8-31
// - host captures read bits on following falls
// - pin returns to lock at edge 32
// - host trusts lock only while strobe low
// - register 0 reads identifier, writes reset/strobes
// - shared-bus frame starts with 24 data
// - then 5-bit register address, edges 25-29
// - then chip address; respond only to 000
// - shared-bus data latched at strobe rise
// - shared-bus frames return pointer-selected register
// - host writes pointer first, reads next frame
// - shared-bus driver enabled only when addressed
`timescale 1ns/1ns
module dsp_device (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    dsp_link_if.device link,
    input wire logic lock_indicator_i,
    output logic [1:0] protocol_o,
    output logic wr_valid_o,
    output logic [5:0] wr_addr_o,
    output logic [23:0] wr_data_o,
    output logic soft_reset_o
);
    // strobe-edge domain
    logic bnd_tgl;
    logic strobe_seen;
    logic strobe_first;
    logic cmt_ok;
    // link domain
    logic clk_first;
    logic bnd_seen;
    logic [5:0] count;
    logic [31:0] shreg;
    logic [31:0] hold;
    logic [23:0] regs [0:dsp_pkg::REG_COUNT-1];
    logic [4:0] rd_ptr;
    logic [23:0] rb_shift;
    logic wr_tgl;
    logic [5:0] wr_addr_q;
    logic [23:0] wr_data_q;
    // link-domain decode
    logic new_frame;
    logic [5:0] edge_num;
    logic st_mode;
    logic sb_mode;
    logic sb_apply;
    logic st_write;
    logic do_wr;
    logic [5:0] wr_addr;
    logic [23:0] wr_data;
    logic [4:0] ptr_eff;
    logic rb_load;
    logic [23:0] rb_word;
    // system domain
    logic [3:0] sync_q;
    logic wr_seen;
    logic wr_event;

    // register 0 reads the identifier; other slots read the stored word
    function automatic logic [23:0] read_reg(input logic [5:0] idx);
        logic [23:0] word;
        word = dsp_pkg::REG_RESET;
        if (idx == dsp_pkg::REG_ID)
            word = dsp_pkg::PART_ID;
        else if (idx < 6'(dsp_pkg::REG_COUNT))
            word = regs[idx[4:0]];
        return word;
    endfunction : read_reg

    ////////////////////////////////////////////////////////////////////////////
    // strobe rising edge: frame boundary, protocol vote, shared-bus latch
    // the link clock is idle here, so shreg and count are steady when read
    always_ff @(posedge link.frame_strobe or posedge rst_i)
    begin
        if (rst_i)
        begin
            bnd_tgl <= 1'b0;
            strobe_seen <= 1'b0;
            strobe_first <= 1'b0;
            cmt_ok <= 1'b0;
            link.readback_oe <= 1'b1;
        end
        else
        begin
            bnd_tgl <= ~bnd_tgl;
            strobe_seen <= 1'b1;
            strobe_first <= strobe_first | ~clk_first;
            cmt_ok <= (count == dsp_pkg::EDGE_LAST);
            // single-target keeps driving; shared-bus drives only when addressed
            link.readback_oe <= strobe_first | ~clk_first
                | (shreg[dsp_pkg::CHIP_W-1:0] == dsp_pkg::CHIP_SELF);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame decode: hold, pointer and mode flags are steady between frames
    always_comb
    begin
        st_mode = strobe_first;
        sb_mode = clk_first | ~strobe_seen;
        new_frame = (bnd_tgl != bnd_seen);
        if (new_frame)
            edge_num = dsp_pkg::EDGE_FIRST;
        else if (count == dsp_pkg::EDGE_OVER)
            edge_num = dsp_pkg::EDGE_OVER;
        else
            edge_num = count + 6'h01;
        // shared-bus commit is applied at the first edge after the strobe rise
        sb_apply = sb_mode && new_frame && cmt_ok
            && (hold[dsp_pkg::CHIP_W-1:0] == dsp_pkg::CHIP_SELF);
        st_write = st_mode && (edge_num == dsp_pkg::EDGE_LAST)
            && !shreg[dsp_pkg::ST_RW_POS];
        do_wr = sb_apply | st_write;
        if (sb_apply)
        begin
            wr_addr = {1'b0, hold[dsp_pkg::SB_ADDR_LSB +: dsp_pkg::SB_ADDR_W]};
            wr_data = hold[dsp_pkg::SB_DATA_LSB +: dsp_pkg::DATA_W];
        end
        else
        begin
            wr_addr = shreg[dsp_pkg::ST_ADDR_LSB +: dsp_pkg::ST_ADDR_W];
            wr_data = shreg[dsp_pkg::DATA_W-1:0];
        end
        if (sb_apply && wr_addr == dsp_pkg::REG_ID)
            ptr_eff = wr_data[dsp_pkg::PTR_LSB +: dsp_pkg::PTR_W];
        else
            ptr_eff = rd_ptr;
        if (sb_mode)
        begin
            rb_load = (edge_num == dsp_pkg::EDGE_FIRST);
            rb_word = read_reg({1'b0, ptr_eff});
        end
        else
        begin
            rb_load = st_mode && (edge_num == dsp_pkg::EDGE_ST_DATA)
                && shreg[dsp_pkg::ST_RW_AT_LOAD];
            rb_word = read_reg(shreg[dsp_pkg::ST_ADDR_W-1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain: protocol flag, edge counter and input shifting
    always_ff @(posedge link.shift_clk or posedge rst_i)
    begin
        if (rst_i)
        begin
            clk_first <= 1'b0;
            bnd_seen <= 1'b0;
            count <= 6'h00;
            shreg <= 32'h00000000;
            hold <= 32'h00000000;
        end
        else
        begin
            clk_first <= clk_first | ~strobe_seen;
            bnd_seen <= bnd_tgl;
            count <= edge_num;
            shreg <= {shreg[30:0], link.serial_in_line};
            if (edge_num == dsp_pkg::EDGE_LAST)
                hold <= {shreg[30:0], link.serial_in_line};
        end
    end

    // register file; soft reset clears contents but never the protocol flags
    always_ff @(posedge link.shift_clk or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < dsp_pkg::REG_COUNT; i++)
                regs[i] <= dsp_pkg::REG_RESET;
            rd_ptr <= 5'h00;
        end
        else if (do_wr)
        begin
            if (wr_addr == dsp_pkg::REG_ID)
            begin
                if (wr_data[dsp_pkg::SOFT_RST_BIT])
                begin
                    for (int i = 0; i < dsp_pkg::REG_COUNT; i++)
                        regs[i] <= dsp_pkg::REG_RESET;
                end
                if (sb_apply)
                    rd_ptr <= wr_data[dsp_pkg::PTR_LSB +: dsp_pkg::PTR_W];
            end
            else if (wr_addr < 6'(dsp_pkg::REG_COUNT))
                regs[wr_addr[4:0]] <= wr_data;
        end
    end

    // readback shifter: MSB launched on the load edge, released at edge 32
    always_ff @(posedge link.shift_clk or posedge rst_i)
    begin
        if (rst_i)
        begin
            rb_shift <= 24'h000000;
            link.readback_data <= 1'b0;
            link.readback_sel <= 1'b0;
        end
        else if (rb_load)
        begin
            link.readback_data <= rb_word[23];
            rb_shift <= {rb_word[22:0], 1'b0};
            link.readback_sel <= 1'b1;
        end
        else if (edge_num == dsp_pkg::EDGE_LAST || new_frame)
        begin
            link.readback_data <= 1'b0;
            link.readback_sel <= 1'b0;
        end
        else if (link.readback_sel)
        begin
            link.readback_data <= rb_shift[23];
            rb_shift <= {rb_shift[22:0], 1'b0};
        end
    end

    // committed word held steady for the system side until the next commit
    always_ff @(posedge link.shift_clk or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_tgl <= 1'b0;
            wr_addr_q <= 6'h00;
            wr_data_q <= 24'h000000;
        end
        else if (do_wr)
        begin
            wr_tgl <= ~wr_tgl;
            wr_addr_q <= wr_addr;
            wr_data_q <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system domain: protocol status, write notices, lock level for the pin
    dsp_sync2 #(
        .WIDTH(4)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .d_i({strobe_first, clk_first, wr_tgl, lock_indicator_i}),
        .q_o(sync_q)
    );

    assign wr_event = sync_q[1] ^ wr_seen;

    // wr_addr_q/wr_data_q are steady long before the toggle arrives here
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            protocol_o <= 2'h0;
            wr_seen <= 1'b0;
            wr_valid_o <= 1'b0;
            wr_addr_o <= 6'h00;
            wr_data_o <= 24'h000000;
            soft_reset_o <= 1'b0;
            link.lock_level <= 1'b0;
        end
        else
        begin
            protocol_o[dsp_pkg::PROTO_ST_BIT] <= sync_q[3];
            protocol_o[dsp_pkg::PROTO_SB_BIT] <= sync_q[2] & ~sync_q[3];
            wr_seen <= sync_q[1];
            wr_valid_o <= wr_event;
            if (wr_event)
            begin
                wr_addr_o <= wr_addr_q;
                wr_data_o <= wr_data_q;
            end
            soft_reset_o <= wr_event && (wr_addr_q == dsp_pkg::REG_ID)
                && wr_data_q[dsp_pkg::SOFT_RST_BIT];
            link.lock_level <= sync_q[0];
        end
    end
endmodule : dsp_device

// ==== hdl/dsp_host.sv ====
// serial master end: builds frames, divides the shift clock, captures readback
`timescale 1ns/1ns
module dsp_host (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    dsp_link_if.host link,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_shared_i,
    input wire logic cmd_read_i,
    input wire logic [5:0] cmd_addr_i,
    input wire logic [23:0] cmd_data_i,
    input wire logic [2:0] cmd_chip_i,
    output logic rsp_valid_o,
    output logic [23:0] rsp_data_o,
    output logic lock_o
);
    dsp_pkg::dsp_host_state_t state;
    logic shared_q;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [3:0] phase;
    logic [5:0] bits;
    logic [3:0] wait_cnt;
    logic pin_s;

    dsp_sync2 #(
        .WIDTH(1)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .d_i(link.lock_or_readback_pin),
        .q_o(pin_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer; the shift clock is divided down from the system clock
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state <= dsp_pkg::H_IDLE;
            shared_q <= 1'b0;
            tx <= 32'h00000000;
            rx <= 32'h00000000;
            phase <= 4'h0;
            bits <= 6'h00;
            wait_cnt <= 4'h0;
            cmd_ready_o <= 1'b1;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 24'h000000;
            link.shift_clk <= 1'b0;
            link.frame_strobe <= 1'b0;
            link.serial_in_line <= 1'b0;
        end
        else
        begin
            rsp_valid_o <= 1'b0;
            unique case (state)
                dsp_pkg::H_IDLE:
                begin
                    if (cmd_valid_i)
                    begin
                        cmd_ready_o <= 1'b0;
                        shared_q <= cmd_shared_i;
                        if (cmd_shared_i)
                        begin
                            // data, register address, chip address
                            tx <= {cmd_data_i, cmd_addr_i[4:0], cmd_chip_i};
                            link.serial_in_line <= cmd_data_i[23];
                        end
                        else
                        begin
                            // flag, address, data; bit after the data is don't-care
                            tx <= {cmd_read_i, cmd_addr_i, cmd_data_i, 1'b0};
                            link.serial_in_line <= cmd_read_i;
                            link.frame_strobe <= 1'b1;
                        end
                        wait_cnt <= 4'(dsp_pkg::SETUP_CYC);
                        state <= dsp_pkg::H_SETUP;
                    end
                end
                dsp_pkg::H_SETUP:
                begin
                    if (wait_cnt == 4'h0)
                    begin
                        phase <= 4'h0;
                        bits <= 6'h00;
                        state <= dsp_pkg::H_SHIFT;
                    end
                    else
                        wait_cnt <= wait_cnt - 4'h1;
                end
                dsp_pkg::H_SHIFT:
                begin
                    phase <= (phase == dsp_pkg::PHASE_WRAP) ? 4'h0 : phase + 4'h1;
                    if (phase == dsp_pkg::PHASE_RISE)
                        link.shift_clk <= 1'b1;
                    if (phase == dsp_pkg::PHASE_FALL)
                    begin
                        link.shift_clk <= 1'b0;
                        rx <= {rx[30:0], pin_s};
                        tx <= {tx[30:0], 1'b0};
                        link.serial_in_line <= tx[30];
                        bits <= bits + 6'h01;
                        if (bits == dsp_pkg::EDGE_LAST - 6'h01)
                            state <= dsp_pkg::H_END;
                    end
                end
                dsp_pkg::H_END:
                begin
                    // shared-bus latches on the strobe rise; single-target ends on the fall
                    link.frame_strobe <= shared_q;
                    rsp_valid_o <= 1'b1;
                    rsp_data_o <= shared_q ? rx[31:8] : rx[24:1];
                    wait_cnt <= 4'(dsp_pkg::HIGH_CYC);
                    state <= dsp_pkg::H_HIGH;
                end
                dsp_pkg::H_HIGH:
                begin
                    if (wait_cnt == 4'h0)
                    begin
                        link.frame_strobe <= 1'b0;
                        wait_cnt <= 4'(dsp_pkg::LOW_CYC);
                        state <= dsp_pkg::H_REST;
                    end
                    else
                        wait_cnt <= wait_cnt - 4'h1;
                end
                dsp_pkg::H_REST:
                begin
                    if (wait_cnt == 4'h0)
                    begin
                        cmd_ready_o <= 1'b1;
                        state <= dsp_pkg::H_IDLE;
                    end
                    else
                        wait_cnt <= wait_cnt - 4'h1;
                end
                default:
                    state <= dsp_pkg::H_IDLE;
            endcase
        end
    end

    // lock level only tracked while no frame runs and the strobe is low
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            lock_o <= 1'b0;
        else if (state == dsp_pkg::H_IDLE && !link.frame_strobe)
            lock_o <= pin_s;
    end
endmodule : dsp_host

// ==== tb/dsp_link_assertions.sv ====
// link checker: readback select, driver enable and data timing against edge numbers
`timescale 1ns/1ns
module dsp_link_assertions (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic shift_clk,
    input wire logic frame_strobe,
    input wire logic serial_in_line,
    input wire logic readback_data,
    input wire logic readback_sel,
    input wire logic readback_oe
);
    logic clk_q;
    logic stb_q;
    logic rd_flag;
    logic [1:0] mode;
    logic [5:0] cnt;
    logic [2:0] last3;
    logic rise;
    logic srise;
    logic [5:0] edge_no;

    // link lines are master flops on this clock, so sampling them here is exact
    assign rise = shift_clk & ~clk_q;
    assign srise = frame_strobe & ~stb_q;
    assign edge_no = cnt + {5'h00, rise};

    // edge numbering restarts at each strobe rise, as the port does
    always_ff @(posedge clk_sys_i)
    begin
        clk_q <= shift_clk;
        stb_q <= frame_strobe;
        if (rst_i || srise)
            cnt <= 6'h00;
        else if (rise)
            cnt <= edge_no;
    end

    // first link event after reset fixes the protocol; flag and chip bits ride along
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            mode <= 2'h0;
        else if (mode == 2'h0 && srise)
            mode <= 2'h1;
        else if (mode == 2'h0 && rise)
            mode <= 2'h2;
        if (rise && edge_no == 6'h01)
            rd_flag <= serial_in_line;
        if (rise)
            last3 <= {last3[1:0], serial_in_line};
    end

    ////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    chk_st_sel_open: assert property (mode == 2'h1 && $rose(readback_sel)
        |-> rise && edge_no == 6'h08 && rd_flag) else $error("st select opened off edge 8");
    chk_sb_sel_open: assert property (mode == 2'h2 && $rose(readback_sel)
        |-> rise && edge_no == 6'h01) else $error("sb select opened off edge 1");
    chk_sel_close: assert property ($fell(readback_sel)
        |-> rise && edge_no == 6'h20) else $error("select closed off edge 32");
    chk_st_oe_held: assert property (mode == 2'h1 |-> readback_oe)
        else $error("st driver disabled");
    chk_sb_oe_chip: assert property (mode == 2'h2 && $rose(frame_strobe)
        |=> readback_oe == (last3 == 3'h0)) else $error("sb driver enable wrong");
    chk_data_steady: assert property (!rise |-> $stable(readback_data))
        else $error("readback changed off a rising edge");
    chk_st_sel_framed: assert property (mode == 2'h1 && readback_sel |-> frame_strobe)
        else $error("st select outside frame");
    chk_sb_sel_quiet: assert property (mode == 2'h2 && readback_sel |-> !frame_strobe)
        else $error("sb select during strobe");

    cover property (mode == 2'h1 && $rose(readback_sel));
    cover property (mode == 2'h2 && $rose(readback_sel));
    cover property (mode == 2'h2 && $fell(readback_oe));
endmodule : dsp_link_assertions

// ==== tb/dual_protocol_serial_port_tb.sv ====
// bench joining master and configuration port: one protocol per power cycle
`timescale 1ns/1ns
module dual_protocol_serial_port_tb;
    logic clk_sys_i, rst_i, lock_indicator_i, lock_o;
    logic cmd_valid_i, cmd_shared_i, cmd_read_i, cmd_ready_o, rsp_valid_o;
    logic [5:0] cmd_addr_i;
    logic [23:0] cmd_data_i;
    logic [2:0] cmd_chip_i;
    logic [23:0] rsp_data_o;
    logic [1:0] protocol_o;
    logic wr_valid_o, soft_reset_o;
    logic [5:0] wr_addr_o;
    logic [23:0] wr_data_o;
    logic [23:0] rsp;
    logic [5:0] wa;
    logic [23:0] wd;
    int n_sr;
    int mismatches;
    int n_checks;
    int cycles;

    dsp_link_if link_inst ();
    dsp_host dsp_host_inst (.clk_sys_i, .rst_i, .link(link_inst.host), .cmd_valid_i,
        .cmd_ready_o, .cmd_shared_i, .cmd_read_i, .cmd_addr_i, .cmd_data_i, .cmd_chip_i,
        .rsp_valid_o, .rsp_data_o, .lock_o);
    dsp_device dsp_device_inst (.clk_sys_i, .rst_i, .link(link_inst.device),
        .lock_indicator_i, .protocol_o, .wr_valid_o, .wr_addr_o, .wr_data_o, .soft_reset_o);
    dsp_link_assertions dsp_link_assertions_inst (.clk_sys_i, .rst_i,
        .shift_clk(link_inst.shift_clk), .frame_strobe(link_inst.frame_strobe),
        .serial_in_line(link_inst.serial_in_line), .readback_data(link_inst.readback_data),
        .readback_sel(link_inst.readback_sel), .readback_oe(link_inst.readback_oe));

    ////////////////////////////////////////
    // 100 MHz system clock
    always #5 clk_sys_i = ~clk_sys_i;

    // catch write pulses mid-cycle, clear of the edge that launches them
    always @(negedge clk_sys_i)
    begin
        if (wr_valid_o === 1'h1)
        begin
            wa = wr_addr_o;
            wd = wr_data_o;
        end
        if (soft_reset_o === 1'h1)
            n_sr++;
    end

    // ten frames of ~270 cycles; the ceiling leaves wide margin
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            complete_run();
        end
    end

    ////////////////////////////////////////
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // reset is the only way to free the protocol choice
    task automatic power_up();
        rst_i = 1'h1;
        repeat (4) @(negedge clk_sys_i);
        rst_i = 1'h0;
        @(negedge clk_sys_i);
    endtask : power_up

    // one whole frame; returns after ready is back so late write pulses have landed
    task automatic frame(input logic sh, input logic rd, input logic [5:0] a,
                         input logic [23:0] d, input logic [2:0] chip);
        while (cmd_ready_o !== 1'h1)
            @(negedge clk_sys_i);
        {cmd_shared_i, cmd_read_i, cmd_addr_i, cmd_data_i, cmd_chip_i} = {sh, rd, a, d, chip};
        cmd_valid_i = 1'h1;
        @(negedge clk_sys_i);
        cmd_valid_i = 1'h0;
        while (rsp_valid_o !== 1'h1)
            @(negedge clk_sys_i);
        rsp = rsp_data_o;
        @(negedge clk_sys_i);
        while (cmd_ready_o !== 1'h1)
            @(negedge clk_sys_i);
    endtask : frame

    ////////////////////////////////////////
    initial
    begin
        {clk_sys_i, rst_i, lock_indicator_i, cmd_valid_i} = 4'h4;
        {cmd_shared_i, cmd_read_i, cmd_addr_i, cmd_data_i, cmd_chip_i} = 35'h0;
        power_up();
        check("protocol", {22'h0, protocol_o}, 24'h000000);
        // single-target: write, read back, identity, soft reset
        frame(1'h0, 1'h0, 6'h03, 24'hA5C3F0, 3'h0);
        check("wr_addr", {18'h0, wa}, 24'h000003);
        check("wr_data", wd, 24'hA5C3F0);
        check("protocol", {22'h0, protocol_o}, 24'h000001);
        frame(1'h0, 1'h1, 6'h03, 24'h000000, 3'h0);
        check("read", rsp, 24'hA5C3F0);
        frame(1'h0, 1'h1, 6'h00, 24'h000000, 3'h0);
        check("ident", rsp, dsp_pkg::PART_ID);
        frame(1'h0, 1'h0, 6'h00, 24'h000020, 3'h0);
        frame(1'h0, 1'h1, 6'h03, 24'h000000, 3'h0);
        check("soft_reset", 24'(n_sr), 24'h000001);
        check("cleared", rsp, 24'h000000);
        check("protocol", {22'h0, protocol_o}, 24'h000001);
        lock_indicator_i = 1'h1;
        repeat (10) @(negedge clk_sys_i);
        check("lock", {23'h0, lock_o}, 24'h000001);
        // shared-bus: commits land at the next frame, readback follows the pointer
        power_up();
        frame(1'h1, 1'h0, 6'h05, 24'h00C3A5, 3'h0);
        check("sb_ident", rsp, dsp_pkg::PART_ID);
        frame(1'h1, 1'h0, 6'h00, 24'h000005, 3'h0);
        check("protocol", {22'h0, protocol_o}, 24'h000002);
        check("wr_addr", {18'h0, wa}, 24'h000005);
        check("wr_data", wd, 24'h00C3A5);
        frame(1'h1, 1'h0, 6'h05, 24'h111111, 3'h5);
        check("pointed", rsp, 24'h00C3A5);
        frame(1'h1, 1'h0, 6'h00, 24'h000005, 3'h0);
        check("undriven", rsp, 24'h000000);
        check("wr_addr", {18'h0, wa}, 24'h000000);
        frame(1'h1, 1'h0, 6'h00, 24'h000005, 3'h0);
        check("kept", rsp, 24'h00C3A5);
        complete_run();
    end
endmodule : dual_protocol_serial_port_tb
